//--- dspm_pin_map.sv
// DRAM strobe pin map: routes row, column and write strobes onto eight pins.
// Assumes request fields are synchronous to clk_sys; pins go to DRAM areas 4 and 5.
//
// How it works
// - Row strobe pin a carries area 4 RAS, pin b area 5 RAS, always.
// - 32-bit dual column: four select pins are lane CAS, write pins are WE.
// - 32-bit lane strobes chosen by address bits 1:0, 00 to 11 lanes 0-3.
// - 32-bit dual write: a-select pins shared CAS, others lane 0-3 WE.
// - 16-bit dual column: per-area low/high CAS on selects, area WE on writes.
// - 16-bit: address bit 0 low picks low byte, high picks high byte.
// - 16-bit dual write: select lo is CAS, select hi low WE, write pin high WE.
// - 8-bit: both area selects carry area CAS, write pins carry area WE.
`timescale 1ns/1ps
module dspm_pin_map
  import dspm_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [1:0]          bus_width,
  input  wire logic                strobe_mode,
  input  wire dspm_pkg::dspm_req_s req,
  output dspm_pkg::dspm_pins_s     pins
);
  import dspm_pkg::*;

  logic [1:0] width_ff;
  logic       mode_ff;
  logic [1:0] nxt_width;
  logic       nxt_mode;
  dspm_pins_s pins_ff;
  dspm_pins_s nxt_pins;
  logic       active;

  // Bit positions must follow the struct field order
  if (RAS_A_POS != 7 || WR_B_POS != 0)
  begin : g_layout_bad
    $error("Pin bundle layout mismatch");
  end

  // Access in progress while any strobe is raised
  assign active = req.ras | req.cas | req.we;

  // Config follows inputs only between accesses
  always_comb
  begin
    nxt_width = width_ff;
    nxt_mode  = mode_ff;
    if (!active)
    begin
      nxt_width = bus_width;
      nxt_mode  = strobe_mode;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      width_ff <= WIDTH_8;
      mode_ff  <= MODE_DUAL_COLUMN;
    end
    else
    begin
      width_ff <= nxt_width;
      mode_ff  <= nxt_mode;
    end
  end

  // One-hot lane decode of the low address bits
  function automatic logic [3:0] lane_dec(input logic [1:0] a);
    lane_dec = 4'h1 << a;
  endfunction : lane_dec

  // Config used for this cycle: held value once an access runs
  logic [1:0] cur_width;
  logic       cur_mode;
  logic [7:0] act;
  logic [3:0] lane;
  logic [1:0] half;
  logic       a4;
  logic       a5;

  always_comb
  begin
    cur_width = active ? width_ff : bus_width;
    cur_mode  = active ? mode_ff : strobe_mode;
    lane      = lane_dec(req.addr_lo);
    half      = req.addr_lo[0] ? 2'h2 : 2'h1;
    a4        = (req.area == AREA_4);
    a5        = (req.area == AREA_5);
    act       = 8'h00;
    act[RAS_A_POS] = req.ras & a4;
    act[RAS_B_POS] = req.ras & a5;
    if (cur_width == WIDTH_32)
    begin
      if (cur_mode == MODE_DUAL_COLUMN)
      begin
        act[SEL_A_LO_POS] = req.cas & lane[0];
        act[SEL_A_HI_POS] = req.cas & lane[1];
        act[SEL_B_LO_POS] = req.cas & lane[2];
        act[SEL_B_HI_POS] = req.cas & lane[3];
        act[WR_A_POS]     = req.we & a4;
        act[WR_B_POS]     = req.we & a5;
      end
      else
      begin
        act[SEL_A_LO_POS] = req.cas;
        act[SEL_A_HI_POS] = req.cas;
        act[SEL_B_LO_POS] = req.we & lane[0];
        act[SEL_B_HI_POS] = req.we & lane[1];
        act[WR_A_POS]     = req.we & lane[2];
        act[WR_B_POS]     = req.we & lane[3];
      end
    end
    else if (cur_width == WIDTH_16)
    begin
      if (cur_mode == MODE_DUAL_COLUMN)
      begin
        act[SEL_A_LO_POS] = req.cas & a4 & half[0];
        act[SEL_A_HI_POS] = req.cas & a4 & half[1];
        act[SEL_B_LO_POS] = req.cas & a5 & half[0];
        act[SEL_B_HI_POS] = req.cas & a5 & half[1];
        act[WR_A_POS]     = req.we & a4;
        act[WR_B_POS]     = req.we & a5;
      end
      else
      begin
        act[SEL_A_LO_POS] = req.cas & a4;
        act[SEL_A_HI_POS] = req.we & a4 & half[0];
        act[WR_A_POS]     = req.we & a4 & half[1];
        act[SEL_B_LO_POS] = req.cas & a5;
        act[SEL_B_HI_POS] = req.we & a5 & half[0];
        act[WR_B_POS]     = req.we & a5 & half[1];
      end
    end
    else
    begin
      act[SEL_A_LO_POS] = req.cas & a4;
      act[SEL_A_HI_POS] = req.cas & a4;
      act[SEL_B_LO_POS] = req.cas & a5;
      act[SEL_B_HI_POS] = req.cas & a5;
      act[WR_A_POS]     = req.we & a4;
      act[WR_B_POS]     = req.we & a5;
    end
    nxt_pins = dspm_pins_s'(~act);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pins_ff <= dspm_pins_s'(PINS_IDLE);
    else
      pins_ff <= nxt_pins;
  end

  assign pins = pins_ff;

  // Assertions
  a_ras_area_map: assert property (@(posedge clk_sys) disable iff (rst)
    req.ras && req.area == AREA_5 |=> !pins.row_strobe_pin_b_n && pins.row_strobe_pin_a_n)
    else $error("Row strobe not on area 5 pin");
  a_lane_32_cas: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_COLUMN && req.addr_lo == 2'h3
    |=> !pins.select_pin_b_hi_n && pins.select_pin_a_lo_n)
    else $error("Lane 3 column strobe wrong");
  a_dual_col_we: assert property (@(posedge clk_sys) disable iff (rst)
    req.we && req.area == AREA_4 && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_COLUMN
    |=> !pins.write_pin_a_n)
    else $error("32-bit write enable missing");
  a_dual_wr_cas: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_WRITE
    |=> !pins.select_pin_a_lo_n && !pins.select_pin_a_hi_n)
    else $error("Shared column strobe missing");
  a_half_sel: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && req.area == AREA_4 && cur_width == WIDTH_16
    && cur_mode == MODE_DUAL_COLUMN && req.addr_lo[0]
    |=> !pins.select_pin_a_hi_n && pins.select_pin_a_lo_n)
    else $error("High byte strobe wrong");
  a_area4_cas16: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && req.area == AREA_5 && cur_width == WIDTH_16 && cur_mode == MODE_DUAL_COLUMN
    |=> pins.select_pin_a_lo_n && pins.select_pin_a_hi_n)
    else $error("Area 4 strobe during area 5 access");
  a_wr16_high: assert property (@(posedge clk_sys) disable iff (rst)
    req.we && req.area == AREA_4 && cur_width == WIDTH_16
    && cur_mode == MODE_DUAL_WRITE && req.addr_lo[0]
    |=> !pins.write_pin_a_n && pins.select_pin_a_hi_n)
    else $error("High byte write enable wrong");
  a_byte_cas: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && req.area == AREA_4 && cur_width == WIDTH_8
    |=> !pins.select_pin_a_lo_n && !pins.select_pin_a_hi_n && pins.select_pin_b_lo_n)
    else $error("8-bit column strobe wrong");
  a_idle_high: assert property (@(posedge clk_sys) disable iff (rst)
    !active |=> pins == dspm_pins_s'(PINS_IDLE))
    else $error("Strobe active while idle");
  a_cfg_hold: assert property (@(posedge clk_sys) disable iff (rst)
    active && $past(active) |-> $stable(width_ff) && $stable(mode_ff))
    else $error("Config changed mid access");
  a_ras_area4: assert property (@(posedge clk_sys) disable iff (rst)
    req.ras && req.area == AREA_4 |=> !pins.row_strobe_pin_a_n && pins.row_strobe_pin_b_n)
    else $error("Row strobe not on area 4 pin");
  a_dw32_lane_we: assert property (@(posedge clk_sys) disable iff (rst)
    req.we && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_WRITE && req.addr_lo == 2'h2
    |=> !pins.write_pin_a_n && pins.select_pin_b_lo_n && pins.write_pin_b_n)
    else $error("Lane 2 write enable wrong");
  a_low_half_sel: assert property (@(posedge clk_sys) disable iff (rst)
    req.cas && req.area == AREA_5 && cur_width == WIDTH_16
    && cur_mode == MODE_DUAL_COLUMN && !req.addr_lo[0]
    |=> !pins.select_pin_b_lo_n && pins.select_pin_b_hi_n)
    else $error("Low byte strobe wrong");
  a_wr16_low: assert property (@(posedge clk_sys) disable iff (rst)
    req.we && req.area == AREA_5 && cur_width == WIDTH_16
    && cur_mode == MODE_DUAL_WRITE && !req.addr_lo[0]
    |=> !pins.select_pin_b_hi_n && pins.write_pin_b_n)
    else $error("Low byte write enable wrong");
  a_byte_we: assert property (@(posedge clk_sys) disable iff (rst)
    req.we && req.area == AREA_5 && cur_width == WIDTH_8
    |=> !pins.write_pin_b_n && pins.write_pin_a_n)
    else $error("8-bit write enable wrong");

  c_w32_dw: cover property (@(posedge clk_sys) disable iff (rst)
    req.we && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_WRITE);
  c_w16_dc: cover property (@(posedge clk_sys) disable iff (rst)
    req.cas && cur_width == WIDTH_16 && cur_mode == MODE_DUAL_COLUMN);
  c_w8: cover property (@(posedge clk_sys) disable iff (rst)
    req.cas && cur_width == WIDTH_8);
  c_w32_dc: cover property (@(posedge clk_sys) disable iff (rst)
    req.cas && cur_width == WIDTH_32 && cur_mode == MODE_DUAL_COLUMN);
  c_w16_dw: cover property (@(posedge clk_sys) disable iff (rst)
    req.we && cur_width == WIDTH_16 && cur_mode == MODE_DUAL_WRITE);

endmodule : dspm_pin_map

//--- dspm_pkg.sv
// Constants and carrier types for the DRAM strobe pin map.
// Assumes one system clock; no software-reachable registers.
package dspm_pkg;

  // Bus width encodings
  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // Strobe arrangement encodings
  localparam logic MODE_DUAL_COLUMN = 1'h0;
  localparam logic MODE_DUAL_WRITE  = 1'h1;

  // Area selector values
  localparam logic AREA_4 = 1'h0;
  localparam logic AREA_5 = 1'h1;

  // Reset value of the pin bundle: all strobes inactive high
  localparam logic [7:0] PINS_IDLE = 8'hFF;

  // Pin positions in the packed bundle
  localparam int RAS_A_POS = 7;
  localparam int RAS_B_POS = 6;
  localparam int SEL_A_LO_POS = 5;
  localparam int SEL_A_HI_POS = 4;
  localparam int SEL_B_LO_POS = 3;
  localparam int SEL_B_HI_POS = 2;
  localparam int WR_A_POS = 1;
  localparam int WR_B_POS = 0;

  // Access request from the memory controller, strobes active high here
  typedef struct packed {
    logic       ras;
    logic       cas;
    logic       we;
    logic       area;
    logic [1:0] addr_lo;
  } dspm_req_s;

  // Eight shared control pins, active low
  typedef struct packed {
    logic row_strobe_pin_a_n;
    logic row_strobe_pin_b_n;
    logic select_pin_a_lo_n;
    logic select_pin_a_hi_n;
    logic select_pin_b_lo_n;
    logic select_pin_b_hi_n;
    logic write_pin_a_n;
    logic write_pin_b_n;
  } dspm_pins_s;

endpackage : dspm_pkg

//--- dspm_dram_model.sv
// DRAM partner: counts row openings seen on each area's row strobe pin.
// Assumes pins come from registers on clk_sys and are active low.
`timescale 1ns/1ps
module dspm_dram_model
  import dspm_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire dspm_pkg::dspm_pins_s pins,
  output int                        opens_a,
  output int                        opens_b
);
  logic prev_a_ff;
  logic prev_b_ff;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prev_a_ff <= 1'b1;
      prev_b_ff <= 1'b1;
      opens_a <= 0;
      opens_b <= 0;
    end
    else
    begin
      prev_a_ff <= pins.row_strobe_pin_a_n;
      prev_b_ff <= pins.row_strobe_pin_b_n;
      if (prev_a_ff && !pins.row_strobe_pin_a_n) opens_a <= opens_a + 1;
      if (prev_b_ff && !pins.row_strobe_pin_b_n) opens_b <= opens_b + 1;
    end
  end
endmodule : dspm_dram_model

//--- dspm_pin_map_tb_top.sv
// Self-checking bench for the DRAM strobe pin map.
// Assumes one clock; expected pins are worked out per bus width and mode.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module dspm_pin_map_tb_top;
  import dspm_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] bus_width = WIDTH_32;
  logic       strobe_mode = MODE_DUAL_COLUMN;
  dspm_req_s  req = '0;
  dspm_pins_s pins;
  int         opens_a;
  int         opens_b;
  int         num_errors = 0;
  int         num_checks = 0;
  always #10 clk_sys = ~clk_sys;
  dspm_pin_map u_dut (.clk_sys(clk_sys), .rst(rst), .bus_width(bus_width),
    .strobe_mode(strobe_mode), .req(req), .pins(pins));
  dspm_dram_model u_dram (.clk_sys(clk_sys), .rst(rst), .pins(pins),
    .opens_a(opens_a), .opens_b(opens_b));
  // Request bits: ras cas we area addr1 addr0
  // Idle cycle carries the new config so it is latched before the access
  task automatic run(input logic [1:0] w, input logic m, input logic [5:0] r,
                     input logic [7:0] e);
    @(posedge clk_sys);
    bus_width <= w;
    strobe_mode <= m;
    req <= '0;
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    #1;
    `CHK("pins", e, pins)
  endtask : run
  // Config change while the previous access still runs
  task automatic run_live(input logic [1:0] w, input logic m, input logic [5:0] r,
                          input logic [7:0] e);
    @(posedge clk_sys);
    bus_width <= w;
    strobe_mode <= m;
    req <= r;
    @(posedge clk_sys);
    #1;
    `CHK("pins", e, pins)
  endtask : run_live
  task automatic t_rows;
    int a0;
    int b0;
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h00, 8'hFF);
    a0 = opens_a;
    b0 = opens_b;
    for (int w = 0; w < 3; w++)
    begin
      run(2'(w), MODE_DUAL_WRITE, 6'h20, 8'h7F);
      run(2'(w), MODE_DUAL_WRITE, 6'h24, 8'hBF);
    end
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h00, 8'hFF);
    `CHK("row opens a", a0 + 3, opens_a)
    `CHK("row opens b", b0 + 3, opens_b)
  endtask : t_rows
  task automatic t_w32;
    for (int i = 0; i < 4; i++)
    begin
      run(WIDTH_32, MODE_DUAL_COLUMN, 6'h10 | 6'(i), 8'hFF ^ (8'h20 >> i));
      run(WIDTH_32, MODE_DUAL_WRITE, 6'h08 | 6'(i), 8'hFF ^ (8'h08 >> i));
    end
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h08, 8'hFD);
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h0C, 8'hFE);
    run(WIDTH_32, MODE_DUAL_WRITE, 6'h17, 8'hCF);
  endtask : t_w32
  task automatic t_w16;
    logic [7:0] wr [4] = '{8'hEF, 8'hFD, 8'hFB, 8'hFE};
    for (int k = 0; k < 4; k++)
    begin
      run(WIDTH_16, MODE_DUAL_COLUMN, 6'h10 | (k[1] ? 6'h04 : 6'h00) | 6'(k[0]),
          8'hFF ^ (8'h20 >> k));
      run(WIDTH_16, MODE_DUAL_WRITE, 6'h08 | (k[1] ? 6'h04 : 6'h00) | 6'(k[0]),
          wr[k]);
    end
    run(WIDTH_16, MODE_DUAL_COLUMN, 6'h0D, 8'hFE);
    run(WIDTH_16, MODE_DUAL_WRITE, 6'h11, 8'hDF);
    run(WIDTH_16, MODE_DUAL_WRITE, 6'h16, 8'hF7);
  endtask : t_w16
  task automatic t_w8;
    run(WIDTH_8, MODE_DUAL_COLUMN, 6'h13, 8'hCF);
    run(WIDTH_8, MODE_DUAL_WRITE, 6'h14, 8'hF3);
    run(WIDTH_8, MODE_DUAL_WRITE, 6'h0A, 8'hFD);
    run(WIDTH_8, MODE_DUAL_COLUMN, 6'h0D, 8'hFE);
    run(WIDTH_8, MODE_DUAL_COLUMN, 6'h03, 8'hFF);
  endtask : t_w8
  task automatic t_hold;
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h00, 8'hFF);
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h20, 8'h7F);
    run_live(WIDTH_8, MODE_DUAL_WRITE, 6'h32, 8'h77);
    run(WIDTH_8, MODE_DUAL_COLUMN, 6'h00, 8'hFF);
    run(WIDTH_8, MODE_DUAL_COLUMN, 6'h12, 8'hCF);
  endtask : t_hold
  // Reset in mid access, request still standing at release
  task automatic t_reset;
    run(WIDTH_32, MODE_DUAL_COLUMN, 6'h20, 8'h7F);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("pins in reset", PINS_IDLE, pins)
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("pins after reset", 8'h7F, pins)
    run(WIDTH_16, MODE_DUAL_COLUMN, 6'h00, 8'hFF);
  endtask : t_reset
  task automatic test_done;
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (5) @(posedge clk_sys);
    `CHK("reset pins", PINS_IDLE, pins)
    rst <= 1'b0;
    t_rows();
    t_w32();
    t_w16();
    t_w8();
    t_hold();
    t_reset();
    test_done();
  end
  initial
  begin
    #100us;
    num_errors++;
    test_done();
  end
endmodule : dspm_pin_map_tb_top
